// ==== logic/rwg_pkg.sv ====
// Purpose: constants and types for the resume well pin bank
// Assumes: byte offsets inside the bank's 64-byte I/O window
// Notes: nine pins occupy bits 8:0 of every register
package rwg_pkg;
  localparam int RWG_PINS = 9;
  localparam logic [5:0] RWG_OFS_ENABLE = 6'h20;
  localparam logic [5:0] RWG_OFS_DIRECTION = 6'h24;
  localparam logic [5:0] RWG_OFS_LEVEL = 6'h28;
  localparam logic [5:0] RWG_OFS_RISE = 6'h2C;
  localparam logic [5:0] RWG_OFS_FALL = 6'h30;
  localparam logic [5:0] RWG_OFS_GEN_EVT = 6'h34;
  localparam logic [5:0] RWG_OFS_MGMT_IRQ = 6'h38;
  localparam logic [5:0] RWG_OFS_STATUS = 6'h3C;
  localparam logic [8:0] RWG_RST_ENABLE = 9'h1FF;
  localparam logic [8:0] RWG_RST_DIRECTION = 9'h1FF;
  localparam logic [8:0] RWG_RST_ZERO = 9'h000;
  localparam logic [8:0] RWG_MUXED_DEFAULT = 9'h1FF;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [5:0] addr;
    logic [31:0] wdata;
  } rwg_req_t;

  typedef struct packed {
    logic [8:0] pin_o;
    logic [8:0] pin_oe;
    logic [8:0] gpio_sel;
  } rwg_pad_t;
endpackage

// ==== logic/rwg_bank.sv ====
// Purpose: resume well general purpose pin bank, nine pins
// Assumes: I/O window decode done upstream; pins synchronous to sys_clk
// Notes: reset is the always-on domain reset only
// Functional notes
// - registers live in a 64-byte I/O window, base decoded outside
// - nine pins on bits 0..8; upper bits reserved
// - enable bit selects gpio versus alternate function; resets to ones
// - direction 1 is input, 0 output; resets to all inputs
// - direction writes ignored for muxed pins whose enable is clear
// - output pins drive the level bit value
// - input pins read pin state; level writes ignored
// - level read undefined when pin disabled
// - enabled rising edge on input pin is a trigger event
// - enabled falling edge on input pin is a trigger event
// - trigger event sets status; both enables catch both edges
// - output pins never set status
// - status sticky, write one clears, zero keeps
// - status and enables set general event pin status
// - status and enables set management interrupt pin status
// - enabled edge also raises a wake event
// - all bits reset only by always-on domain reset
// - bits of absent pins read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
module rwg_bank
  import rwg_pkg::*;
#(
  parameter logic [8:0] MUXED = rwg_pkg::RWG_MUXED_DEFAULT
) (
  // clock and always-on reset
  input wire logic sys_clk,
  input wire logic reset,
  // register access
  input wire rwg_pkg::rwg_req_t req,
  output logic [31:0] rdata,
  // pins
  input wire logic [8:0] pin_i,
  output var rwg_pkg::rwg_pad_t pad,
  // upstream event controls and status
  input wire logic general_event_pin_enable,
  input wire logic mgmt_irq_pin_enable,
  output logic general_event_pin_status,
  output logic mgmt_irq_pin_status,
  output logic wake_event
);
  import rwg_pkg::*;

  logic [8:0] en_q, en_d, dir_q, dir_d, lvl_q, lvl_d;
  logic [8:0] rise_q, rise_d, fall_q, fall_d, gpe_q, gpe_d, smi_q, smi_d;
  logic [8:0] sts_q, sts_d, s1_q, s2_q, prev_q;
  logic [31:0] rdata_q, rdata_d;
  logic gps_q, gps_d, mis_q, mis_d, wake_q, wake_d;
  logic [8:0] is_in, rise_ev, fall_ev, ev, wdat;

  assign wdat = req.wdata[8:0];
  assign is_in = dir_q;

  // compare synced samples, one detector per pin
  for (genvar g = 0; g < RWG_PINS; g++) begin : g_edge
    always_comb begin
      rise_ev[g] = is_in[g] & rise_q[g] & s2_q[g] & ~prev_q[g];
      fall_ev[g] = is_in[g] & fall_q[g] & ~s2_q[g] & prev_q[g];
      ev[g] = rise_ev[g] | fall_ev[g];
    end
  end

  always_comb begin
    en_d = en_q;
    dir_d = dir_q;
    lvl_d = lvl_q;
    rise_d = rise_q;
    fall_d = fall_q;
    gpe_d = gpe_q;
    smi_d = smi_q;
    sts_d = sts_q;
    if (req.wr_en) begin
      case (req.addr)
        RWG_OFS_ENABLE: en_d = wdat;
        RWG_OFS_DIRECTION: dir_d = (dir_q & MUXED & ~en_q) | (wdat & ~(MUXED & ~en_q));
        RWG_OFS_LEVEL: lvl_d = (lvl_q & is_in) | (wdat & ~is_in);
        RWG_OFS_RISE: rise_d = wdat;
        RWG_OFS_FALL: fall_d = wdat;
        RWG_OFS_GEN_EVT: gpe_d = wdat;
        RWG_OFS_MGMT_IRQ: smi_d = wdat;
        RWG_OFS_STATUS: sts_d = sts_q & ~wdat;
        default: ;
      endcase
    end
    sts_d = sts_d | ev;
    // level flags are sticky until upstream logic resets the domain
    gps_d = gps_q | |(sts_q & gpe_q & is_in & {9{general_event_pin_enable}});
    mis_d = mis_q | |(sts_q & smi_q & is_in & {9{mgmt_irq_pin_enable}});
    wake_d = |ev;
    rdata_d = 32'h0;
    if (req.rd_en) begin
      case (req.addr)
        RWG_OFS_ENABLE: rdata_d = {23'h0, en_q};
        RWG_OFS_DIRECTION: rdata_d = {23'h0, dir_q};
        RWG_OFS_LEVEL: rdata_d = {23'h0, (s2_q & is_in) | (lvl_q & ~is_in)};
        RWG_OFS_RISE: rdata_d = {23'h0, rise_q};
        RWG_OFS_FALL: rdata_d = {23'h0, fall_q};
        RWG_OFS_GEN_EVT: rdata_d = {23'h0, gpe_q};
        RWG_OFS_MGMT_IRQ: rdata_d = {23'h0, smi_q};
        RWG_OFS_STATUS: rdata_d = {23'h0, sts_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // only the always-on reset clears state
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      en_q <= RWG_RST_ENABLE;
      dir_q <= RWG_RST_DIRECTION;
      lvl_q <= RWG_RST_ZERO;
      rise_q <= RWG_RST_ZERO;
      fall_q <= RWG_RST_ZERO;
      gpe_q <= RWG_RST_ZERO;
      smi_q <= RWG_RST_ZERO;
    end else begin
      en_q <= en_d;
      dir_q <= dir_d;
      lvl_q <= lvl_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      gpe_q <= gpe_d;
      smi_q <= smi_d;
    end
  end

  // two-flop sampler plus one history flop; reset low so idle-low pins give no false edge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_q <= RWG_RST_ZERO;
      s2_q <= RWG_RST_ZERO;
      prev_q <= RWG_RST_ZERO;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end

  // sticky status, routed flags and read data
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sts_q <= RWG_RST_ZERO;
      rdata_q <= 32'h0;
      gps_q <= 1'b0;
      mis_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      rdata_q <= rdata_d;
      gps_q <= gps_d;
      mis_q <= mis_d;
      wake_q <= wake_d;
    end
  end

  assign rdata = rdata_q;
  assign pad.pin_o = lvl_q;
  assign pad.pin_oe = en_q & ~dir_q;
  assign pad.gpio_sel = en_q | ~MUXED;
  assign general_event_pin_status = gps_q;
  assign mgmt_irq_pin_status = mis_q;
  assign wake_event = wake_q;

  property p_sts_sticky;
    @(posedge sys_clk) disable iff (reset)
      (sts_q[0] && !(req.wr_en && req.addr == RWG_OFS_STATUS && req.wdata[0])) |=> sts_q[0];
  endproperty
  a_sts_sticky: assert property (p_sts_sticky) else $error("status bit lost");

  property p_set_wins;
    @(posedge sys_clk) disable iff (reset) ev[0] |=> sts_q[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("edge event dropped");

  property p_out_no_sts;
    @(posedge sys_clk) disable iff (reset) (!dir_q[1] && !sts_q[1]) |=> !sts_q[1] || $past(ev[1]);
  endproperty
  a_out_no_sts: assert property (p_out_no_sts) else $error("status set on output");

  sequence s_rise0;
    !s2_q[2] ##1 s2_q[2] && dir_q[2] && rise_q[2];
  endsequence
  property p_rise;
    @(posedge sys_clk) disable iff (reset) s_rise0 |=> sts_q[2] && wake_q;
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");

  sequence s_fall0;
    s2_q[3] ##1 !s2_q[3] && dir_q[3] && fall_q[3];
  endsequence
  property p_fall;
    @(posedge sys_clk) disable iff (reset) s_fall0 |=> sts_q[3] && wake_q;
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");

  property p_drive;
    @(posedge sys_clk) disable iff (reset)
      (req.wr_en && req.addr == RWG_OFS_LEVEL && !dir_q[4]) |=> pad.pin_o[4] == $past(req.wdata[4]);
  endproperty
  a_drive: assert property (p_drive) else $error("output not driven");

  property p_dir_lock;
    @(posedge sys_clk) disable iff (reset)
      (MUXED[5] && !en_q[5] && req.wr_en && req.addr == RWG_OFS_DIRECTION) |=> $stable(dir_q[5]);
  endproperty
  a_dir_lock: assert property (p_dir_lock) else $error("locked direction changed");

  property p_gpe;
    @(posedge sys_clk) disable iff (reset)
      (sts_q[6] && gpe_q[6] && dir_q[6] && general_event_pin_enable) |=> general_event_pin_status;
  endproperty
  a_gpe: assert property (p_gpe) else $error("general event not routed");

  property p_smi;
    @(posedge sys_clk) disable iff (reset)
      (sts_q[7] && smi_q[7] && dir_q[7] && mgmt_irq_pin_enable) |=> mgmt_irq_pin_status;
  endproperty
  a_smi: assert property (p_smi) else $error("management irq not routed");

  property p_rsvd;
    @(posedge sys_clk) disable iff (reset) rdata[31:9] == 23'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

  property p_en_write;
    @(posedge sys_clk) disable iff (reset)
      (req.wr_en && req.addr == RWG_OFS_ENABLE) |=> en_q == $past(req.wdata[8:0]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost");

  property p_dir_write;
    @(posedge sys_clk) disable iff (reset)
      (req.wr_en && req.addr == RWG_OFS_DIRECTION && en_q[6]) |=> dir_q[6] == $past(req.wdata[6]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_lvl_hold;
    @(posedge sys_clk) disable iff (reset)
      (req.wr_en && req.addr == RWG_OFS_LEVEL && dir_q[1]) |=> $stable(lvl_q[1]);
  endproperty
  a_lvl_hold: assert property (p_lvl_hold) else $error("input level overwritten");

  sequence s_lvl_rd;
    req.rd_en && req.addr == RWG_OFS_LEVEL && dir_q[0];
  endsequence
  property p_lvl_read;
    @(posedge sys_clk) disable iff (reset) s_lvl_rd |=> rdata[0] == $past(s2_q[0]);
  endproperty
  a_lvl_read: assert property (p_lvl_read) else $error("input level not returned");

  sequence s_clr0;
    req.wr_en && req.addr == RWG_OFS_STATUS && req.wdata[0] && !ev[0];
  endsequence
  property p_clear;
    @(posedge sys_clk) disable iff (reset) s_clr0 |=> !sts_q[0];
  endproperty
  a_clear: assert property (p_clear) else $error("status not cleared");

  property p_both;
    @(posedge sys_clk) disable iff (reset)
      (rise_q[5] && fall_q[5] && dir_q[5] && s2_q[5] != prev_q[5]) |=> sts_q[5];
  endproperty
  a_both: assert property (p_both) else $error("either-edge event missed");

  property p_wake_quiet;
    @(posedge sys_clk) disable iff (reset) !(|ev) |=> !wake_event;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("wake without edge");

  property p_gps_hold;
    @(posedge sys_clk) disable iff (reset) general_event_pin_status |=> general_event_pin_status;
  endproperty
  a_gps_hold: assert property (p_gps_hold) else $error("general event status lost");

  property p_mis_hold;
    @(posedge sys_clk) disable iff (reset) mgmt_irq_pin_status |=> mgmt_irq_pin_status;
  endproperty
  a_mis_hold: assert property (p_mis_hold) else $error("management irq status lost");

  property p_idle_rd;
    @(posedge sys_clk) disable iff (reset) !req.rd_en |=> rdata == 32'h0;
  endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data without read");

  property p_unmapped;
    @(posedge sys_clk) disable iff (reset) (req.rd_en && req.addr < RWG_OFS_ENABLE) |=> rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped offset read nonzero");

  property p_sync;
    @(posedge sys_clk) disable iff (reset) s2_q == $past(s1_q) && prev_q == $past(s2_q);
  endproperty
  a_sync: assert property (p_sync) else $error("sampler chain broken");

  property p_sel;
    @(posedge sys_clk) disable iff (reset) (MUXED[0] && !en_q[0]) |-> !pad.gpio_sel[0] && !pad.pin_oe[0];
  endproperty
  a_sel: assert property (p_sel) else $error("disabled pin still gpio");
endmodule
`default_nettype wire

// ==== test/rwg_pin_model.sv ====
// Purpose: outside parts wired to the nine resume pins
// Assumes: outside parts drive only pins the bank leaves undriven
// Notes: contention is not modelled
`timescale 1ns/1ps
`default_nettype none
module rwg_pin_model (
  // bank side
  input wire rwg_pkg::rwg_pad_t pad,
  // outside level
  input wire logic [8:0] ext_lvl,
  output logic [8:0] pin_i
);
  import rwg_pkg::*;
  // a driven pin reads back its own level, so output toggles reach the sampler
  assign pin_i = (pad.pin_oe & pad.pin_o) | (~pad.pin_oe & ext_lvl);
endmodule
`default_nettype wire

// ==== test/test_resume_well_gpio_bank.sv ====
// Purpose: self-checking bench for the resume pin bank
// Assumes: one access per cycle, rdata checked the cycle after the strobe
// Notes: random pin and level changes with sticky status tracked here
`timescale 1ns/1ps
`default_nettype none
module test_resume_well_gpio_bank;
  import rwg_pkg::*;
  logic sys_clk = 0, reset = 1, gen_en = 0, mgmt_en = 0, gen_sts, mgmt_sts, wake, seen;
  rwg_req_t req = '0;
  rwg_pad_t pad;
  logic [31:0] rdata;
  logic [8:0] pin_i, ext_lvl = '0, dir, lvl, rise, fall, sts, prev, now, edges, m;
  int error_cnt = 0, checked = 0, seed = 32'hE8215965;
  rwg_bank rwg_bank_i (.sys_clk(sys_clk), .reset(reset), .req(req), .rdata(rdata), .pin_i(pin_i), .pad(pad),
    .general_event_pin_enable(gen_en), .mgmt_irq_pin_enable(mgmt_en), .general_event_pin_status(gen_sts),
    .mgmt_irq_pin_status(mgmt_sts), .wake_event(wake));
  rwg_pin_model rwg_pin_model_i (.pad(pad), .ext_lvl(ext_lvl), .pin_i(pin_i));
  initial forever #12.5 sys_clk = ~sys_clk;
  function automatic logic [8:0] pins(input logic [8:0] d, l, e);
    return (~d & l) | (d & e);
  endfunction
  task automatic cmp(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // strobes stay up until the next access or idle, so no signal is set twice in one step
  task automatic wr(input logic [5:0] a, input logic [8:0] d);
    req = '{1'b1, 1'b0, a, {23'h7FFFFF, d}};
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    req = '{1'b0, 1'b1, a, 32'h0};
    @(posedge sys_clk);
    #1 cmp(rdata, exp);
  endtask
  task automatic idle(input int n);
    req = '0;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000 error_cnt++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 reset = 0;
    rd(6'h20, 32'h1FF);
    rd(6'h24, 32'h1FF);
    rd(6'h28, 32'h0);
    for (int a = 'h2C; a <= 'h3C; a += 4) rd(a[5:0], 32'h0);
    rd(6'h00, 32'h0);
    wr(6'h2C, 9'h1FF);
    rd(6'h2C, 32'h1FF);
    wr(6'h20, 9'h1FE);
    wr(6'h24, 9'h000);
    rd(6'h24, 32'h1);
    cmp(pad.gpio_sel, 32'h1FE);
    wr(6'h20, 9'h1FF);
    dir = $random(seed) | 9'h100;
    lvl = $random(seed);
    wr(6'h24, dir);
    wr(6'h28, lvl);
    ext_lvl = $random(seed);
    idle(4);
    rd(6'h28, pins(dir, lvl, ext_lvl));
    cmp({pad.pin_oe, pad.pin_o & ~dir}, {~dir, lvl & ~dir});
    rise = $random(seed);
    fall = $random(seed);
    wr(6'h2C, rise);
    wr(6'h30, fall);
    wr(6'h3C, 9'h1FF);
    sts = '0;
    for (int i = 0; i < 60; i++) begin
      prev = pins(dir, lvl, ext_lvl);
      if (i % 3 == 0) wr(6'h28, ($random(seed) & ~dir) | (lvl & dir));
      else ext_lvl = $random(seed);
      if (i % 3 == 0) lvl = req.wdata[8:0];
      req = '0;
      seen = 0;
      repeat (6) begin
        @(posedge sys_clk);
        #1 seen |= wake;
      end
      now = pins(dir, lvl, ext_lvl);
      edges = ((rise & ~prev & now) | (fall & prev & ~now)) & dir;
      sts |= edges;
      cmp(seen, |edges);
      rd(6'h3C, sts);
      m = $random(seed);
      wr(6'h3C, m);
      sts &= ~m;
    end
    wr(6'h2C, 9'h1FF);
    wr(6'h38, 9'h1FF);
    ext_lvl[8] = 0;
    idle(6);
    wr(6'h3C, 9'h1FF);
    ext_lvl[8] = 1;
    idle(6);
    rd(6'h3C, 32'h100);
    cmp(mgmt_sts, 0);
    gen_en = 1;
    wr(6'h34, 9'h100);
    idle(4);
    cmp({gen_sts, mgmt_sts}, 2'b10);
    mgmt_en = 1;
    idle(4);
    cmp(mgmt_sts, 1);
    reset = 1;
    idle(2);
    reset = 0;
    cmp({gen_sts, mgmt_sts}, 0);
    rd(6'h24, 32'h1FF);
    tally_and_finish;
  end
endmodule
`default_nettype wire
